// ===== logic/ses_params.svh
// Constants of the SPI EEPROM command sequencer
`ifndef SES_PARAMS_SVH
`define SES_PARAMS_SVH

// ************************************
// Opcodes
// ************************************
`define SES_OP_WR_EN    8'h06
`define SES_OP_READ     8'h03
`define SES_OP_WRITE    8'h02
`define SES_OP_WR_DIS   8'h04
`define SES_OP_RD_STAT  8'h05
`define SES_OP_WR_STAT  8'h01
`define SES_OP_SET_FLAG 8'h00

// ************************************
// Status bit positions
// ************************************
`define SES_SR_PEN      7
`define SES_SR_FLAG     6
`define SES_SR_WD_HI    5
`define SES_SR_WD_LO    4
`define SES_SR_BL_HI    3
`define SES_SR_BL_LO    2
`define SES_SR_LATCH    1
`define SES_SR_BUSY     0

// ************************************
// Reset values, sizes and timing
// ************************************
`define SES_NV_RST      5'h00
`define SES_PAGE_BITS   5
`define SES_ADDR_BITS   13
`define SES_WR_TIME_US  10000
`define SES_CLK_MHZ     50
`define SES_WR_CYCLES   (`SES_WR_TIME_US * `SES_CLK_MHZ)

`endif

// ===== logic/ses_pkg.sv
// Types of the SPI EEPROM command sequencer
package ses_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_ARRAY, ST_STATUS} ses_state_t;
endpackage : ses_pkg

// ===== logic/ses_top.sv
// SPI EEPROM command sequencer: serial front end and write engine
`timescale 1ns/100ps
`default_nettype none
`include "ses_params.svh"

module ses_top
	import ses_pkg::*;
#(
	parameter int AW        = `SES_ADDR_BITS,
	parameter int WR_CYCLES = `SES_WR_CYCLES
)(
	// Core clock and reset
	input  wire logic core_clk,
	input  wire logic nrst,
	// Serial link
	input  wire logic sck,
	input  wire logic cs_n,
	input  wire logic si,
	output logic      so_out,
	output logic      so_oe,
	// Protect pin
	input  wire logic wp_n
);

	localparam int PB = `SES_PAGE_BITS;

	initial
	begin
		if (AW <= PB || AW > 16 || WR_CYCLES < 1 || WR_CYCLES >= (1 << 20))
			$error("ses_top: unsupported parameters");
	end

	// ************************************
	// Storage
	// ************************************
	logic [7:0]       mem      [0:(1<<AW)-1];
	logic [7:0]       pbuf     [0:(1<<PB)-1];
	logic [(1<<PB)-1:0] pvalid_r;

	// ************************************
	// Core domain state
	// ************************************
	ses_state_t       state_r;
	logic [19:0]      tmr_r;
	logic             latch_r;
	logic             ftg_seen_r;
	logic             flag_r;
	logic             pen_r;
	logic [1:0]       wd_r;
	logic [1:0]       bl_r;
	logic [2:0]       cs_sync_r;
	logic [1:0]       wp_sync_r;
	logic [2:0]       ftg_sync_r;
	logic             armed_r;
	logic             frame_ok_r;
	logic [7:0]       status;

	// ************************************
	// Link domain state
	// ************************************
	logic             frame_rst_n;
	logic             frame_act_r;
	logic             ftg_r;
	logic [2:0]       bit_r;
	logic [2:0]       byte_r;
	logic [6:0]       sh_r;
	logic [7:0]       op_r;
	logic [15:0]      addr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW-PB-1:0] page_r;
	logic [PB-1:0]    wptr_r;
	logic [7:0]       sr_data_r;
	logic [7:0]       tx_r;
	logic             tx_act_r;
	logic             so_oe_r;
	logic [7:0]       st_m_r;
	logic [7:0]       st_s_r;
	logic [2:0]       cur_bit;
	logic [2:0]       cur_byte;
	logic             byte_done;
	logic [7:0]       rx_byte;
	logic [15:0]      addr_in;
	logic             busy_s;

	// ************************************
	// Link front end
	// ************************************
	assign frame_rst_n = nrst & ~cs_n;
	assign cur_bit     = frame_act_r ? bit_r : 3'h0;
	assign cur_byte    = frame_act_r ? byte_r : 3'h0;
	assign byte_done   = (cur_bit == 3'h7);
	assign rx_byte     = {sh_r, si};
	assign addr_in     = {addr_r[14:0], si};
	assign busy_s      = st_s_r[`SES_SR_BUSY];

	always_ff @(posedge sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			frame_act_r <= 1'b0;
		else
			frame_act_r <= 1'b1;
	end

	// Marks each frame that saw clocks, so an empty select pulse repeats nothing
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
			ftg_r <= 1'b0;
		else if (!frame_act_r && !cs_n)
			ftg_r <= ~ftg_r;
	end

	// Counts survive the select rise so the core can judge the frame
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			bit_r  <= 3'h0;
			byte_r <= 3'h0;
		end
		else if (!cs_n)
		begin
			bit_r <= cur_bit + 3'h1;
			if (byte_done && cur_byte != 3'h7)
				byte_r <= cur_byte + 3'h1;
			else
				byte_r <= cur_byte;
		end
	end

	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			sh_r <= 7'h00;
			op_r <= `SES_OP_SET_FLAG;
		end
		else
		begin
			sh_r <= rx_byte[6:0];
			if (byte_done && cur_byte == 3'h0)
				op_r <= rx_byte;
		end
	end

	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
			addr_r <= 16'h0000;
		else if (cur_byte == 3'h1 || cur_byte == 3'h2)
			addr_r <= addr_in;
	end

	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
			sr_data_r <= 8'h00;
		else if (byte_done && cur_byte == 3'h1 && op_r == `SES_OP_WR_STAT)
			sr_data_r <= rx_byte;
	end

	// ************************************
	// Read data path
	// ************************************
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			tx_r     <= 8'h00;
			rd_ptr_r <= '0;
		end
		else if (byte_done)
		begin
			if (cur_byte == 3'h0 && rx_byte == `SES_OP_RD_STAT)
				tx_r <= st_s_r;
			else if (cur_byte != 3'h0 && op_r == `SES_OP_RD_STAT)
				tx_r <= st_s_r;
			else if (cur_byte == 3'h2 && op_r == `SES_OP_READ)
			begin
				tx_r     <= mem[addr_in[AW-1:0]];
				rd_ptr_r <= addr_in[AW-1:0] + 1'b1;
			end
			else if (cur_byte > 3'h2 && op_r == `SES_OP_READ)
			begin
				tx_r     <= mem[rd_ptr_r];
				rd_ptr_r <= rd_ptr_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			tx_act_r <= 1'b0;
		else if (byte_done && ((cur_byte == 3'h0 && rx_byte == `SES_OP_RD_STAT) ||
			(cur_byte == 3'h2 && op_r == `SES_OP_READ)))
			tx_act_r <= 1'b1;
	end

	// Falling edge launch gives the host a full half period of setup
	always_ff @(negedge sck or negedge frame_rst_n)
	begin
		if (!frame_rst_n)
			so_oe_r <= 1'b0;
		else
			so_oe_r <= tx_act_r;
	end

	always_ff @(negedge sck or negedge nrst)
	begin
		if (!nrst)
			so_out <= 1'b0;
		else
			so_out <= tx_r[3'h7 - bit_r];
	end

	// Frames begun before cs_n is first seen high never drive the pin
	assign so_oe = so_oe_r & armed_r;

	// ************************************
	// Page buffer
	// ************************************
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			page_r   <= '0;
			wptr_r   <= '0;
			pvalid_r <= '0;
		end
		else if (byte_done && op_r == `SES_OP_WRITE && !busy_s)
		begin
			if (cur_byte == 3'h2)
			begin
				page_r   <= addr_in[AW-1:PB];
				wptr_r   <= addr_in[PB-1:0];
				pvalid_r <= '0;
			end
			else if (cur_byte > 3'h2)
			begin
				pvalid_r[wptr_r] <= 1'b1;
				wptr_r           <= wptr_r + 1'b1;
			end
		end
	end

	always_ff @(posedge sck)
	begin
		if (byte_done && cur_byte > 3'h2 && op_r == `SES_OP_WRITE && !busy_s)
			pbuf[wptr_r] <= rx_byte;
	end

	// Bits may tear by one edge only when a write ends mid-frame
	always_ff @(posedge sck or negedge nrst)
	begin
		if (!nrst)
		begin
			st_m_r <= 8'h00;
			st_s_r <= 8'h00;
		end
		else
		begin
			st_m_r <= status;
			st_s_r <= st_m_r;
		end
	end

	// ************************************
	// Core synchronisers and frame judge
	// ************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cs_sync_r  <= 3'h0;
			wp_sync_r  <= 2'h0;
			ftg_sync_r <= 3'h0;
		end
		else
		begin
			cs_sync_r  <= {cs_sync_r[1:0], cs_n};
			wp_sync_r  <= {wp_sync_r[0], wp_n};
			ftg_sync_r <= {ftg_sync_r[1:0], ftg_r};
		end
	end

	logic cs_s;
	logic cs_rise;
	logic cs_fall;
	logic wp_s;
	logic frame_new;
	logic wr_en_ok;
	logic wr_dis_ok;
	logic set_flag_ok;
	logic wr_stat_ok;
	logic write_ok;
	logic sr_open;
	logic pg_locked;
	logic start_arr;
	logic start_sr;

	assign cs_s      = cs_sync_r[1];
	assign cs_rise   = cs_sync_r[1] & ~cs_sync_r[2];
	assign cs_fall   = ~cs_sync_r[1] & cs_sync_r[2];
	assign wp_s      = wp_sync_r[1];
	assign frame_new = cs_rise && frame_ok_r && (ftg_sync_r[1] ^ ftg_sync_r[2] || ftg_sync_r[2] != ftg_seen_r);

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			ftg_seen_r <= 1'b0;
		else if (cs_rise)
			ftg_seen_r <= ftg_sync_r[1];
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			armed_r    <= 1'b0;
			frame_ok_r <= 1'b0;
		end
		else
		begin
			armed_r <= armed_r | cs_s;
			if (cs_fall)
				frame_ok_r <= armed_r;
		end
	end

	assign wr_en_ok    = frame_new && op_r == `SES_OP_WR_EN && byte_r == 3'h1 && bit_r == 3'h0;
	assign wr_dis_ok   = frame_new && op_r == `SES_OP_WR_DIS && byte_r == 3'h1 && bit_r == 3'h0;
	assign set_flag_ok = frame_new && op_r == `SES_OP_SET_FLAG && byte_r == 3'h1 && bit_r == 3'h0;
	assign wr_stat_ok  = frame_new && op_r == `SES_OP_WR_STAT && byte_r == 3'h2 && bit_r == 3'h0;
	assign write_ok = frame_new && op_r == `SES_OP_WRITE && byte_r >= 3'h4 && bit_r == 3'h0;
	assign sr_open  = !pen_r || wp_s;
	assign pg_locked = (bl_r == 2'h3) ||
		(bl_r == 2'h2 && page_r[AW-PB-1]) ||
		(bl_r == 2'h1 && page_r[AW-PB-1 -: 2] == 2'h3);
	assign start_arr = write_ok && state_r == ST_IDLE && latch_r && !pg_locked;
	assign start_sr  = wr_stat_ok && state_r == ST_IDLE && latch_r && sr_open;
	assign status    = {pen_r, flag_r, wd_r, bl_r, latch_r, state_r != ST_IDLE};

	// ************************************
	// Write engine
	// ************************************
	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= ST_IDLE;
			tmr_r   <= 20'h00000;
		end
		else
		begin
			unique case (state_r)
				ST_IDLE:
				begin
					tmr_r <= 20'(WR_CYCLES - 1);
					if (start_arr)
						state_r <= ST_ARRAY;
					else if (start_sr)
						state_r <= ST_STATUS;
				end
				ST_ARRAY, ST_STATUS:
				begin
					tmr_r <= tmr_r - 20'h00001;
					if (tmr_r == 20'h00000)
						state_r <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			latch_r <= 1'b0;
			flag_r  <= 1'b0;
		end
		else
		begin
			if (state_r != ST_IDLE && tmr_r == 20'h00000)
				latch_r <= 1'b0;
			else if (wr_en_ok && state_r == ST_IDLE)
				latch_r <= 1'b1;
			else if (wr_dis_ok && state_r == ST_IDLE)
				latch_r <= 1'b0;
			if (state_r == ST_STATUS && tmr_r == 20'h00000)
				flag_r <= sr_data_r[`SES_SR_FLAG];
			else if (set_flag_ok)
				flag_r <= 1'b1;
			else if (wr_dis_ok)
				flag_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			{pen_r, wd_r, bl_r} <= `SES_NV_RST;
		else if (state_r == ST_STATUS && tmr_r == 20'h00000)
		begin
			pen_r <= sr_data_r[`SES_SR_PEN];
			wd_r  <= sr_data_r[`SES_SR_WD_HI:`SES_SR_WD_LO];
			bl_r  <= sr_data_r[`SES_SR_BL_HI:`SES_SR_BL_LO];
		end
	end

	// Array is nonvolatile: no reset, updated only as a write cycle ends
	always_ff @(posedge core_clk)
	begin
		if (state_r == ST_ARRAY && tmr_r == 20'h00000)
		begin
			for (int i = 0; i < (1 << PB); i++)
				if (pvalid_r[i])
					mem[{page_r, PB'(i)}] <= pbuf[i];
		end
	end

	// ************************************
	// Checks
	// ************************************
	property p_sr_lock;
		@(posedge core_clk) disable iff (!nrst)
		start_sr |-> (!pen_r || wp_s);
	endproperty
	a_sr_lock: assert property (p_sr_lock) else $error("status write began while locked");

	property p_sr_finish;
		@(posedge core_clk) disable iff (!nrst)
		(state_r == ST_STATUS && tmr_r != 20'h00000) |=> state_r == ST_STATUS;
	endproperty
	a_sr_finish: assert property (p_sr_finish) else $error("status write cut short");

	property p_wp_high;
		@(posedge core_clk) disable iff (!nrst)
		(wr_stat_ok && state_r == ST_IDLE && latch_r && wp_s) |=> state_r == ST_STATUS;
	endproperty
	a_wp_high: assert property (p_wp_high) else $error("status write refused with WP high");

	property p_pen_clear;
		@(posedge core_clk) disable iff (!nrst)
		(wr_stat_ok && state_r == ST_IDLE && latch_r && !pen_r) |=> state_r == ST_STATUS;
	endproperty
	a_pen_clear: assert property (p_pen_clear) else $error("status write refused with protect clear");

	property p_en_exact;
		@(posedge core_clk) disable iff (!nrst)
		$rose(latch_r) |-> $past(op_r == `SES_OP_WR_EN && byte_r == 3'h1 && bit_r == 3'h0);
	endproperty
	a_en_exact: assert property (p_en_exact) else $error("latch set without clean enable frame");

	property p_commit_count;
		@(posedge core_clk) disable iff (!nrst)
		(state_r == ST_IDLE ##1 state_r == ST_ARRAY) |-> $past(byte_r >= 3'h4 && bit_r == 3'h0);
	endproperty
	a_commit_count: assert property (p_commit_count) else $error("array write began on bad count");

	property p_latch_clear;
		@(posedge core_clk) disable iff (!nrst)
		(state_r != ST_IDLE && tmr_r == 20'h00000) |=> (!latch_r && state_r == ST_IDLE);
	endproperty
	a_latch_clear: assert property (p_latch_clear) else $error("latch kept after write cycle");

	property p_arr_guard;
		@(posedge core_clk) disable iff (!nrst)
		start_arr |-> (latch_r && !pg_locked && state_r == ST_IDLE);
	endproperty
	a_arr_guard: assert property (p_arr_guard) else $error("array write began unguarded");

	property p_busy_len;
		@(posedge core_clk) disable iff (!nrst)
		(state_r == ST_IDLE && start_arr) |=> (state_r == ST_ARRAY)[*8];
	endproperty
	a_busy_len: assert property (p_busy_len) else $error("write cycle ended too soon");

endmodule : ses_top

`default_nettype wire

// ===== verif/ses_host.sv
// Host SPI master model driving the sequencer's serial link
`timescale 1ns/100ps
`default_nettype none

module ses_host (
	// Serial link
	output logic       sck,
	output logic       cs_n,
	output logic       si,
	input  wire logic  so_out,
	input  wire logic  so_oe,
	// Received bytes
	output logic [7:0] rx_byte,
	output logic       rx_stb
);
	initial
	begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end

	// ****************************************
	// One frame: bytes out, optional stray bits, bytes in
	// ****************************************
	// Clock only runs inside frames; idle SI flips so stale data never looks valid
	task automatic frame(input logic [7:0] tx[$], input int extra, input int nrx, output logic [7:0] last);
		logic [7:0] b;
		last = 8'h00;
		b = 8'h00;
		cs_n = 1'b0;
		for (int i = 0; i < tx.size() * 8 + extra; i++)
		begin
			si = (i < tx.size() * 8) ? tx[i / 8][7 - i % 8] : 1'b0;
			#6 sck = 1'b1;
			#6 sck = 1'b0;
		end
		for (int k = 0; k < nrx; k++)
		begin
			for (int j = 7; j >= 0; j--)
			begin
				#6 sck = 1'b1;
				b[j] = so_oe ? so_out : 1'bx;
				#6 sck = 1'b0;
			end
			rx_byte = b;
			rx_stb = ~rx_stb;
			last = b;
		end
		#6 cs_n = 1'b1;
		si = ~si;
		#120;
	endtask : frame
endmodule : ses_host

`default_nettype wire

// ===== verif/tb_ses_top.sv
// Self-checking testbench of the SPI EEPROM command sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ses_params.svh"

module tb_ses_top;
	logic        core_clk;
	logic        nrst;
	logic        wp_n;
	logic        sck;
	logic        cs_n;
	logic        si;
	wire logic   so_out;
	wire logic   so_oe;
	logic [7:0]  rx_byte;
	logic        rx_stb;
	logic [15:0] exp_q[$];
	logic [7:0]  pg[$];
	logic [7:0]  ex[$];
	logic [7:0]  junk;
	int          failures = 0;
	int          checked = 0;

	ses_top #(.WR_CYCLES(20)) DUT (
		.core_clk (core_clk),
		.nrst     (nrst),
		.sck      (sck),
		.cs_n     (cs_n),
		.si       (si),
		.so_out   (so_out),
		.so_oe    (so_oe),
		.wp_n     (wp_n)
	);

	ses_host host (
		.sck     (sck),
		.cs_n    (cs_n),
		.si      (si),
		.so_out  (so_out),
		.so_oe   (so_oe),
		.rx_byte (rx_byte),
		.rx_stb  (rx_stb)
	);

	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end

	// ****************************************
	// Checking and closing
	// ****************************************
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("BAD t=%0t seen %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	// Mask of zero marks a poll whose value is not judged
	initial
	begin
		logic [15:0] e;
		forever
		begin
			@(rx_stb);
			e = exp_q.pop_front();
			if (e[15:8] != 8'h00)
				check(rx_byte & e[15:8], e[7:0]);
		end
	end

	initial
	begin
		#400000;
		failures++;
		report_and_stop();
	end

	// ****************************************
	// Frame helpers
	// ****************************************
	task automatic cmd(input logic [7:0] tx[$], input int extra = 0);
		logic [7:0] d;
		host.frame(tx, extra, 0, d);
	endtask : cmd

	task automatic expect_sr(input logic [7:0] e);
		logic [7:0] d;
		exp_q.push_back({8'hFF, e});
		host.frame({`SES_OP_RD_STAT}, 0, 1, d);
	endtask : expect_sr

	task automatic wait_idle();
		logic [7:0] d;
		int         n;
		d = 8'h01;
		n = 0;
		while (d[0] !== 1'b0 && n < 40)
		begin
			exp_q.push_back(16'h0000);
			host.frame({`SES_OP_RD_STAT}, 0, 1, d);
			n++;
		end
		check({7'h00, d[0]}, 8'h00);
	endtask : wait_idle

	task automatic expect_rd(input logic [15:0] a, input logic [7:0] e[$]);
		logic [7:0] d;
		foreach (e[i])
			exp_q.push_back({8'hFF, e[i]});
		host.frame({`SES_OP_READ, a[15:8], a[7:0]}, 0, e.size(), d);
		check({7'h00, so_oe}, 8'h00);
	endtask : expect_rd

	task automatic wr_arr(input logic [15:0] a, input logic [7:0] d[$]);
		logic [7:0] tx[$];
		tx = d;
		tx.push_front(a[7:0]);
		tx.push_front(a[15:8]);
		tx.push_front(`SES_OP_WRITE);
		cmd({`SES_OP_WR_EN});
		cmd(tx);
		wait_idle();
	endtask : wr_arr

	task automatic wr_sr(input logic [7:0] v);
		cmd({`SES_OP_WR_EN});
		cmd({`SES_OP_WR_STAT, v});
		wait_idle();
	endtask : wr_sr

	// ****************************************
	// Tests
	// ****************************************
	initial
	begin
		nrst = 1'b0;
		wp_n = 1'b1;
		void'($urandom(32'h5836));
		repeat (8) @(posedge core_clk);
		@(negedge core_clk) nrst = 1'b1;
		repeat (4) @(negedge core_clk);
		check({7'h00, so_oe}, 8'h00);
		expect_sr(8'h00);
		$display("test power-up done");

		cmd({`SES_OP_WR_EN});
		expect_sr(8'h02);
		cmd({`SES_OP_SET_FLAG});
		expect_sr(8'h42);
		cmd({`SES_OP_WR_DIS});
		expect_sr(8'h00);
		cmd({`SES_OP_WR_EN, `SES_OP_WRITE});
		expect_sr(8'h00);
		$display("test latch and flag done");

		for (int i = 0; i < 33; i++)
			pg.push_back(8'($urandom));
		cmd({`SES_OP_WR_EN});
		cmd({`SES_OP_WRITE, 8'h00, 8'h20, pg[0], pg[1], pg[2], pg[3]}, 0);
		wait_idle();
		pg.push_front(8'h20);
		pg.push_front(8'h00);
		pg.push_front(`SES_OP_WRITE);
		cmd({`SES_OP_WR_EN});
		cmd(pg);
		exp_q.push_back({8'h01, 8'h01});
		host.frame({`SES_OP_RD_STAT}, 0, 1, junk);
		wait_idle();
		expect_sr(8'h00);
		pg = pg[3:$];
		ex = pg[1:31];
		ex.push_front(pg[32]);
		expect_rd(16'h0020, ex);
		$display("test page write done");

		cmd({`SES_OP_WR_EN});
		cmd({`SES_OP_WRITE, 8'h00, 8'h20, 8'hAA}, 3);
		cmd({`SES_OP_WRITE, 8'h00, 8'h20});
		expect_sr(8'h02);
		expect_rd(16'h0020, {pg[32], pg[1]});
		cmd({`SES_OP_WR_DIS});
		wr_arr(16'h1FFF, {8'hA5});
		wr_arr(16'h0000, {8'h5A});
		expect_rd(16'h1FFF, {8'hA5, 8'h5A});
		$display("test abort and wrap done");

		@(negedge core_clk) wp_n = 1'b0;
		wr_sr(8'h8C);
		expect_sr(8'h8C);
		wr_sr(8'h00);
		expect_sr(8'h8E);
		cmd({`SES_OP_WRITE, 8'h00, 8'h20, 8'h11});
		wait_idle();
		expect_rd(16'h0020, {pg[32]});
		@(negedge core_clk) wp_n = 1'b1;
		cmd({`SES_OP_WR_STAT, 8'h00});
		wait_idle();
		expect_sr(8'h00);
		cmd({`SES_OP_WR_EN});
		cmd({`SES_OP_WR_STAT, 8'h80});
		@(negedge core_clk) wp_n = 1'b0;
		wait_idle();
		expect_sr(8'h80);
		wr_sr(8'h00);
		expect_sr(8'h82);
		$display("test protect done");
		report_and_stop();
	end
endmodule : tb_ses_top

`default_nettype wire
